//--- shared/pi4_dqpsk_pkg.sv
// Constants and helper functions shared by the differential SHIFT_MODE_SELECT symbol encoder
package pi4_dqpsk_pkg;
   // Bit period in system clocks for each rate, symbol spans two bits
   localparam int unsigned BIT_DIV_HS = 40;
   localparam int unsigned BIT_DIV_LS = 320;
   localparam int unsigned SYM_CYC_HS = 2 * BIT_DIV_HS;
   localparam int unsigned SYM_CYC_LS = 2 * BIT_DIV_LS;
   localparam int TIMER_W = 10;
   localparam logic [TIMER_W-1:0] SYM_RELOAD_HS = TIMER_W'(SYM_CYC_HS - 1);
   localparam logic [TIMER_W-1:0] SYM_RELOAD_LS = TIMER_W'(SYM_CYC_LS - 1);

   localparam int PRBS_W = 9;
   localparam logic [PRBS_W-1:0] PRBS_SEED = 9'h1ff;
   localparam int PRBS_TAP = 4;

   localparam int DIBIT_W = 2;
   localparam int FIFO_DEPTH = 16;

   // Phase is an octant index, one step per pi/4
   localparam int PHASE_W = 3;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 3'h0;
   localparam logic [PHASE_W-1:0] DELTA_00 = 3'h1;
   localparam logic [PHASE_W-1:0] DELTA_01 = 3'h3;
   localparam logic [PHASE_W-1:0] DELTA_10 = 3'h7;
   localparam logic [PHASE_W-1:0] DELTA_11 = 3'h5;
   localparam logic [PHASE_W-1:0] NONSHIFT_ADJ = 3'h1;
   localparam logic [PHASE_W-1:0] QUAD_OFFSET = 3'h2;

   localparam int LEVEL_W = 8;
   localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'h7f;
   localparam logic [LEVEL_W-1:0] LEVEL_DIAG = 8'h5a;
   localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 8'h00;

   // Declared ahead of its caller so package lookup never sees a forward name
   function automatic logic [LEVEL_W-1:0] LEVEL_WIDTH_NEG(input logic [LEVEL_W-1:0] a);
      return LEVEL_W'(~a + 8'h01);
   endfunction

   // Cosine of an octant as a signed level
   function automatic logic [LEVEL_W-1:0] cos_level(input logic [PHASE_W-1:0] oct);
      logic [LEVEL_W-1:0] v;
      v = LEVEL_ZERO;
      unique case (oct)
         3'h0: v = LEVEL_FULL;
         3'h1, 3'h7: v = LEVEL_DIAG;
         3'h2, 3'h6: v = LEVEL_ZERO;
         3'h3, 3'h5: v = LEVEL_WIDTH_NEG(LEVEL_DIAG);
         3'h4: v = LEVEL_WIDTH_NEG(LEVEL_FULL);
      endcase
      return v;
   endfunction
endpackage

//--- design/dibit_cdc_fifo.sv
// Dual-clock FIFO with gray-coded pointers carrying di-bits to the system clock
`timescale 1ns/1ns
module dibit_cdc_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
) (
   input wire logic i_wr_clk,
   input wire logic i_wr_rst,
   input wire logic i_wr_valid,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_wr_ready,
   input wire logic i_rd_clk,
   input wire logic i_rd_rst,
   output logic o_rd_valid,
   output logic [WIDTH-1:0] o_rd_data,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] bin;
      logic [PW-1:0] gray;
      logic [PW-1:0] rg_s1;
      logic [PW-1:0] rg_s2;
   } wr_s;

   typedef struct packed {
      logic [PW-1:0] bin;
      logic [PW-1:0] gray;
      logic [PW-1:0] wg_s1;
      logic [PW-1:0] wg_s2;
      logic valid;
      logic [WIDTH-1:0] data;
   } rd_s;

   wr_s w_ff, nxt_w;
   rd_s r_ff, nxt_r;
   logic full;
   logic empty;
   logic [PW-1:0] wb;
   logic [PW-1:0] rb;

   // Full when the write pointer is a whole lap ahead of the synced read pointer
   assign full = (w_ff.gray == {~w_ff.rg_s2[PW-1:PW-2], w_ff.rg_s2[PW-3:0]});
   assign empty = (r_ff.gray == r_ff.wg_s2);
   assign o_wr_ready = ~full;
   assign o_rd_valid = r_ff.valid;
   assign o_rd_data = r_ff.data;

   always_comb begin
      nxt_w = w_ff;
      wb = w_ff.bin;
      nxt_w.rg_s1 = r_ff.gray;
      nxt_w.rg_s2 = w_ff.rg_s1;
      if (i_wr_valid && !full) begin
         nxt_w.mem[w_ff.bin[AW-1:0]] = i_wr_data;
         wb = PW'(w_ff.bin + 1'b1);
         nxt_w.bin = wb;
         nxt_w.gray = wb ^ (wb >> 1);
      end
   end

   always_ff @(posedge i_wr_clk) begin
      if (i_wr_rst) begin
         w_ff <= '0;
      end else begin
         w_ff <= nxt_w;
      end
   end

   // Slot is written before its pointer becomes visible, so the read is stable
   always_comb begin
      nxt_r = r_ff;
      rb = r_ff.bin;
      nxt_r.wg_s1 = w_ff.gray;
      nxt_r.wg_s2 = r_ff.wg_s1;
      if (!empty && (!r_ff.valid || i_rd_ready)) begin
         nxt_r.data = w_ff.mem[r_ff.bin[AW-1:0]];
         nxt_r.valid = 1'b1;
         rb = PW'(r_ff.bin + 1'b1);
         nxt_r.bin = rb;
         nxt_r.gray = rb ^ (rb >> 1);
      end else if (i_rd_ready) begin
         nxt_r.valid = 1'b0;
      end
   end

   always_ff @(posedge i_rd_clk) begin
      if (i_rd_rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end
endmodule

//--- design/pi4_dqpsk_symbol_encoder.sv
// Differential SHIFT_MODE_SELECT symbol encoder core: bit capture, test sequence and phase coding
`timescale 1ns/1ns
module pi4_dqpsk_symbol_encoder
   import pi4_dqpsk_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic I_BIT_SHIFT_CLOCK,
   input wire logic I_TXD,
   input wire logic I_SLOT_VALID,
   input wire logic I_TEST_PATTERN_SELECT,
   input wire logic I_SHIFT_MODE_SELECT,
   input wire logic I_RATE_SELECT,
   input wire logic I_RESET_POWERDOWN_N,
   output logic O_SYM_STROBE,
   output logic [DIBIT_W-1:0] O_DIBIT,
   output logic [PHASE_W-1:0] O_PHASE,
   output logic [LEVEL_W-1:0] O_I_LEVEL,
   output logic [LEVEL_W-1:0] O_Q_LEVEL,
   output logic [1:0] O_POL_CHANGE,
   output logic [1:0] O_PREV_SYMBOL_IQ,
   output logic O_CORE_RUN,
   output logic O_PATTERN_MONITOR_OUT,
   output logic O_FIFO_OVERRUN
);
   // System clock domain state
   typedef struct packed {
      logic rp_s1;
      logic rp_s2;
      logic sm_s1;
      logic sm_s2;
      logic rs_s1;
      logic rs_s2;
      logic run;
      logic [TIMER_W-1:0] timer;
      logic [PHASE_W-1:0] phase;
      logic [1:0] prev_symbol_iq;
      logic [LEVEL_W-1:0] i_lvl;
      logic [LEVEL_W-1:0] q_lvl;
      logic [1:0] chg;
      logic stb;
      logic [DIBIT_W-1:0] dibit;
   } sys_s;

   // Bit clock domain state
   typedef struct packed {
      logic run_s1;
      logic run_s2;
      logic tst_s1;
      logic tst_s2;
      logic [PRBS_W-1:0] prbs;
      logic have_first;
      logic dibit_first;
      logic mon;
      logic ovr;
   } link_s;

   sys_s s_ff, nxt_s;
   link_s l_ff, nxt_l;

   logic fifo_wr_valid;
   logic [DIBIT_W-1:0] fifo_wr_data;
   logic fifo_wr_ready;
   logic fifo_rd_valid;
   logic [DIBIT_W-1:0] fifo_rd_data;
   logic take;
   logic link_bit;
   logic link_rst;
   logic sys_rst;
   logic [PHASE_W-1:0] delta;
   logic [PHASE_W-1:0] new_phase;
   logic [1:0] new_iq;

   assign link_rst = ~l_ff.run_s2;
   assign sys_rst = I_SRST | ~s_ff.run;

   // ---------------- Bit clock domain ----------------
   // Test sequence replaces the serial data when selected
   // data source select
   assign link_bit = l_ff.tst_s2 ? l_ff.prbs[PRBS_W-1] : I_TXD;

   // A pair completes on the second valid bit; the first bit is the first di-bit bit
   // serial to parallel
   assign fifo_wr_valid = I_SLOT_VALID & l_ff.have_first & l_ff.run_s2;
   assign fifo_wr_data = {l_ff.dibit_first, link_bit};

   always_comb begin
      nxt_l = l_ff;
      nxt_l.run_s1 = s_ff.run;
      nxt_l.run_s2 = l_ff.run_s1;
      nxt_l.tst_s1 = I_TEST_PATTERN_SELECT;
      nxt_l.tst_s2 = l_ff.tst_s1;
      if (link_rst) begin
         // only the core reset seeds the generator
         nxt_l.prbs = PRBS_SEED;
         nxt_l.have_first = 1'b0;
         nxt_l.dibit_first = 1'b0;
         nxt_l.mon = 1'b0;
         nxt_l.ovr = 1'b0;
      end else begin
         // bits counted only inside the slot
         if (I_SLOT_VALID) begin
            if (l_ff.have_first) begin
               nxt_l.have_first = 1'b0;
            end else begin
               nxt_l.have_first = 1'b1;
               nxt_l.dibit_first = link_bit;
            end
            // Sequence steps with the data shift timing, not free running
            if (l_ff.tst_s2) begin
               nxt_l.prbs = {l_ff.prbs[PRBS_W-2:0], l_ff.prbs[PRBS_W-1] ^ l_ff.prbs[PRBS_TAP]};
            end
         end else begin
            // Odd bit at slot end has no partner and is dropped
            nxt_l.have_first = 1'b0;
         end
         nxt_l.mon = l_ff.tst_s2 & l_ff.prbs[PRBS_W-1];
         // Bit clock cannot be stalled, so a full buffer loses the pair and flags it
         if (fifo_wr_valid && !fifo_wr_ready) begin
            nxt_l.ovr = 1'b1;
         end
      end
   end

   always_ff @(posedge I_BIT_SHIFT_CLOCK) begin
      l_ff <= nxt_l;
   end

   dibit_cdc_fifo #(
      .WIDTH(DIBIT_W),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .i_wr_clk(I_BIT_SHIFT_CLOCK),
      .i_wr_rst(link_rst),
      .i_wr_valid(fifo_wr_valid),
      .i_wr_data(fifo_wr_data),
      .o_wr_ready(fifo_wr_ready),
      .i_rd_clk(I_CLK),
      .i_rd_rst(sys_rst),
      .o_rd_valid(fifo_rd_valid),
      .o_rd_data(fifo_rd_data),
      .i_rd_ready(take)
   );

   // ---------------- System clock domain ----------------
   // one symbol per paced slot
   assign take = fifo_rd_valid & (s_ff.timer == '0) & s_ff.run;

   always_comb begin
      delta = DELTA_00;
      unique case (fifo_rd_data)
         2'h0: delta = DELTA_00;
         2'h1: delta = DELTA_01;
         2'h2: delta = DELTA_10;
         2'h3: delta = DELTA_11;
      endcase
      // plain mode drops the extra pi/4
      if (!s_ff.sm_s2) begin
         delta = PHASE_W'(delta - NONSHIFT_ADJ);
      end
      new_phase = PHASE_W'(s_ff.phase + delta);
   end

   always_comb begin
      nxt_s = s_ff;
      new_iq = s_ff.prev_symbol_iq;
      nxt_s.rp_s1 = I_RESET_POWERDOWN_N;
      nxt_s.rp_s2 = s_ff.rp_s1;
      nxt_s.sm_s1 = I_SHIFT_MODE_SELECT;
      nxt_s.sm_s2 = s_ff.sm_s1;
      nxt_s.rs_s1 = I_RATE_SELECT;
      nxt_s.rs_s2 = s_ff.rs_s1;
      // core runs only after pin rises
      nxt_s.run = s_ff.rp_s2;
      nxt_s.stb = 1'b0;
      if (!s_ff.run) begin
         nxt_s.timer = '0;
         nxt_s.phase = PHASE_RESET;
         nxt_s.prev_symbol_iq = 2'h0;
         nxt_s.i_lvl = cos_level(PHASE_RESET);
         nxt_s.q_lvl = cos_level(PHASE_W'(PHASE_RESET - QUAD_OFFSET));
         nxt_s.chg = 2'h0;
         nxt_s.dibit = '0;
      end else begin
         if (s_ff.timer != '0) begin
            nxt_s.timer = TIMER_W'(s_ff.timer - 1'b1);
         end
         if (take) begin
            nxt_s.phase = new_phase;
            nxt_s.i_lvl = cos_level(new_phase);
            nxt_s.q_lvl = cos_level(PHASE_W'(new_phase - QUAD_OFFSET));
            new_iq = {nxt_s.i_lvl[LEVEL_W-1], nxt_s.q_lvl[LEVEL_W-1]};
            nxt_s.chg = new_iq ^ s_ff.prev_symbol_iq;
            nxt_s.prev_symbol_iq = new_iq;
            nxt_s.dibit = fifo_rd_data;
            nxt_s.stb = 1'b1;
            nxt_s.timer = s_ff.rs_s2 ? SYM_RELOAD_LS : SYM_RELOAD_HS;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign O_SYM_STROBE = s_ff.stb;
   assign O_DIBIT = s_ff.dibit;
   assign O_PHASE = s_ff.phase;
   assign O_I_LEVEL = s_ff.i_lvl;
   assign O_Q_LEVEL = s_ff.q_lvl;
   assign O_POL_CHANGE = s_ff.chg;
   assign O_PREV_SYMBOL_IQ = s_ff.prev_symbol_iq;
   assign O_CORE_RUN = s_ff.run;
   assign O_PATTERN_MONITOR_OUT = l_ff.mon;
   assign O_FIFO_OVERRUN = l_ff.ovr;
endmodule

//--- test/bit_source.sv
// Baseband controller model: bit clock, serial bits and slot window
`timescale 1ns/1ns
module bit_source (
   output logic o_bclk,
   output logic o_txd,
   output logic o_slot_valid
);
   initial begin
      o_bclk = 1'b0;
      o_txd = 1'b0;
      o_slot_valid = 1'b0;
   end
   // data held across the rising edge
   task automatic pulse();
      #32 o_bclk = 1'b1;
      #32 o_bclk = 1'b0;
   endtask
   // Clock runs only inside frames and in the idle runs the test asks for, around resets, test pattern select changes and between slots
   task automatic idle(input int n);
      repeat (n) pulse();
   endtask
   // window spans exactly the sent bits; data line inverted afterwards
   task automatic send(input logic [79:0] b, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         o_slot_valid = 1'b1;
         o_txd = b[k];
         pulse();
      end
      o_slot_valid = 1'b0;
      o_txd = ~o_txd;
      pulse();
   endtask
endmodule

//--- test/pi4_dqpsk_symbol_encoder_sva.sv
// Port-level assertions for the symbol encoder
`timescale 1ns/1ns
module pi4_dqpsk_sva
   import pi4_dqpsk_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic I_BIT_SHIFT_CLOCK,
   input wire logic I_TEST_PATTERN_SELECT,
   input wire logic I_SHIFT_MODE_SELECT,
   input wire logic I_RATE_SELECT,
   input wire logic I_RESET_POWERDOWN_N,
   input wire logic O_SYM_STROBE,
   input wire logic [DIBIT_W-1:0] O_DIBIT,
   input wire logic [PHASE_W-1:0] O_PHASE,
   input wire logic [1:0] O_POL_CHANGE,
   input wire logic [1:0] O_PREV_SYMBOL_IQ,
   input wire logic O_CORE_RUN,
   input wire logic O_PATTERN_MONITOR_OUT,
   input wire logic O_FIFO_OVERRUN
);
   logic [9:0] gap_ff;
   // Saturates so the first symbol after reset is never judged
   always_ff @(posedge I_CLK) begin
      if (I_SRST || !O_CORE_RUN) begin
         gap_ff <= '1;
      end else if (O_SYM_STROBE) begin
         gap_ff <= '0;
      end else if (gap_ff != '1) begin
         gap_ff <= gap_ff + 10'h001;
      end
   end
   function automatic logic [2:0] step(input logic [1:0] d, input logic s);
      logic [2:0] v;
      v = d[1] ? (d[0] ? DELTA_11 : DELTA_10) : (d[0] ? DELTA_01 : DELTA_00);
      return s ? v : v - NONSHIFT_ADJ;
   endfunction
   sequence s_pin_low;
      !I_RESET_POWERDOWN_N [*4];
   endsequence
   sequence s_test_off;
      !I_TEST_PATTERN_SELECT [*5];
   endsequence
   a_strobe_pulse: assert property (@(posedge I_CLK) disable iff (I_SRST)
      O_SYM_STROBE |=> !O_SYM_STROBE) else $error("strobe wider than one cycle");
   a_state_holds: assert property (@(posedge I_CLK) disable iff (I_SRST || !O_CORE_RUN)
      !O_SYM_STROBE |-> $stable(O_PHASE) && $stable(O_PREV_SYMBOL_IQ))
      else $error("symbol state moved without strobe");
   a_phase_step: assert property (@(posedge I_CLK) disable iff (I_SRST || !O_CORE_RUN)
      O_SYM_STROBE |-> O_PHASE == 3'($past(O_PHASE) + step(O_DIBIT, I_SHIFT_MODE_SELECT)))
      else $error("phase step wrong for di-bit");
   a_pol_change: assert property (@(posedge I_CLK) disable iff (I_SRST || !O_CORE_RUN)
      O_SYM_STROBE |-> O_POL_CHANGE == (O_PREV_SYMBOL_IQ ^ $past(O_PREV_SYMBOL_IQ)))
      else $error("polarity change flags wrong");
   a_sym_spacing: assert property (@(posedge I_CLK) disable iff (I_SRST || !O_CORE_RUN)
      O_SYM_STROBE |-> gap_ff >= (I_RATE_SELECT ? 10'h27f : 10'h04f))
      else $error("symbols closer than rate allows");
   a_pin_holds: assert property (@(posedge I_CLK) disable iff (I_SRST)
      s_pin_low |-> !O_CORE_RUN) else $error("core running with pin low");
   a_idle_phase: assert property (@(posedge I_CLK) disable iff (I_SRST)
      !O_CORE_RUN |=> O_PHASE == PHASE_RESET) else $error("phase not reset");
   a_monitor_quiet: assert property (@(posedge I_BIT_SHIFT_CLOCK)
      disable iff (I_SRST || !O_CORE_RUN) s_test_off |-> !O_PATTERN_MONITOR_OUT)
      else $error("monitor active outside test mode");
   a_overrun_sticky: assert property (@(posedge I_BIT_SHIFT_CLOCK)
      disable iff (I_SRST || !O_CORE_RUN) O_FIFO_OVERRUN |=> O_FIFO_OVERRUN)
      else $error("overrun flag dropped");
endmodule
bind pi4_dqpsk_symbol_encoder pi4_dqpsk_sva i_sva (.I_CLK, .I_SRST, .I_BIT_SHIFT_CLOCK,
   .I_TEST_PATTERN_SELECT, .I_SHIFT_MODE_SELECT, .I_RATE_SELECT, .I_RESET_POWERDOWN_N,
   .O_SYM_STROBE, .O_DIBIT, .O_PHASE, .O_POL_CHANGE, .O_PREV_SYMBOL_IQ, .O_CORE_RUN,
   .O_PATTERN_MONITOR_OUT, .O_FIFO_OVERRUN);

//--- test/tb_top.sv
// Self-checking bench for the symbol encoder
`timescale 1ns/1ns
module tb_top;
   import pi4_dqpsk_pkg::*;
   logic I_CLK, I_SRST, I_TEST_PATTERN_SELECT;
   logic I_SHIFT_MODE_SELECT, I_RATE_SELECT, I_RESET_POWERDOWN_N;
   logic bclk, txd, slot, O_SYM_STROBE, O_CORE_RUN, O_PATTERN_MONITOR_OUT, O_FIFO_OVERRUN;
   logic mon_seen;
   logic [1:0] O_DIBIT, O_POL_CHANGE, O_PREV_SYMBOL_IQ, eiq, d;
   logic [2:0] O_PHASE, eph;
   logic [7:0] O_I_LEVEL, O_Q_LEVEL, li, lq;
   logic [8:0] prbs;
   logic [79:0] pb;
   logic [1:0] expq[$];
   int mismatches = 0, cmp_count = 0, cyc = 0, tlast = 0, gap = 0, nsym = 0, w;
   pi4_dqpsk_symbol_encoder #(.FIFO_WORDS(FIFO_DEPTH)) i_pi4_dqpsk_symbol_encoder (.I_CLK,
      .I_SRST, .I_BIT_SHIFT_CLOCK(bclk), .I_TXD(txd), .I_SLOT_VALID(slot),
      .I_TEST_PATTERN_SELECT, .I_SHIFT_MODE_SELECT, .I_RATE_SELECT, .I_RESET_POWERDOWN_N,
      .O_SYM_STROBE, .O_DIBIT, .O_PHASE, .O_I_LEVEL, .O_Q_LEVEL, .O_POL_CHANGE,
      .O_PREV_SYMBOL_IQ, .O_CORE_RUN, .O_PATTERN_MONITOR_OUT, .O_FIFO_OVERRUN);
   bit_source i_bit_source (.o_bclk(bclk), .o_txd(txd), .o_slot_valid(slot));
   initial begin
      I_CLK = 1'b0;
      forever #50 I_CLK = ~I_CLK;
   end
   always @(posedge I_CLK) cyc++;
   // Looked at mid-period, away from the edge that launches it
   always @(negedge bclk) if (O_PATTERN_MONITOR_OUT === 1'b1) mon_seen = 1'b1;
   function automatic logic [7:0] lvl(input logic [2:0] o);
      case (o)
         3'h0: return 8'h7f;
         3'h1, 3'h7: return 8'h5a;
         3'h2, 3'h6: return 8'h00;
         3'h3, 3'h5: return 8'ha6;
         default: return 8'h81;
      endcase
   endfunction
   function automatic logic [2:0] step(input logic [1:0] d, input logic s);
      logic [2:0] v;
      v = d[1] ? (d[0] ? DELTA_11 : DELTA_10) : (d[0] ? DELTA_01 : DELTA_00);
      return s ? v : v - NONSHIFT_ADJ;
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Expected symbol model, sampled mid-cycle where outputs are settled
   always @(negedge I_CLK) begin
      if (O_SYM_STROBE === 1'b1) begin
         nsym++;
         gap = cyc - tlast;
         tlast = cyc;
         d = (expq.size() > 0) ? expq.pop_front() : 2'h0;
         eph = eph + step(d, I_SHIFT_MODE_SELECT);
         li = lvl(eph);
         lq = lvl(eph - QUAD_OFFSET);
         chk("dibit", O_DIBIT, d);
         chk("phase", O_PHASE, eph);
         chk("i level", O_I_LEVEL, li);
         chk("q level", O_Q_LEVEL, lq);
         chk("polarity", O_POL_CHANGE, eiq ^ {li[7], lq[7]});
         eiq = {li[7], lq[7]};
         chk("previous iq", O_PREV_SYMBOL_IQ, eiq);
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge I_CLK);
      #1;
   endtask
   // Odd trailing bit of a slot has no partner and is not expected
   task automatic xmit(input logic [79:0] b, input int n, input logic inv);
      for (int k = n - 1; k > 0; k -= 2) expq.push_back({b[k], b[k-1]});
      i_bit_source.send(inv ? ~b : b, n);
      tlast = cyc;
   endtask
   task automatic drain();
      while (cyc - tlast < 700) tick(1);
   endtask
   task automatic sreset();
      I_SRST = 1'b1;
      // Bit clock runs while the core is held so the link side and buffer reset too
      fork
         i_bit_source.idle(6);
         tick(5);
      join
      I_SRST = 1'b0;
      tick(4);
      i_bit_source.idle(4);
      eph = PHASE_RESET;
      eiq = 2'h0;
      prbs = PRBS_SEED;
   endtask
   initial begin
      #3_000_000;
      mismatches++;
      $display("[FAIL] watchdog expected finish seen timeout");
      conclude();
   end
   initial begin
      I_SRST = 1'b1;
      I_TEST_PATTERN_SELECT = 1'b0;
      I_SHIFT_MODE_SELECT = 1'b1;
      I_RATE_SELECT = 1'b0;
      I_RESET_POWERDOWN_N = 1'b1;
      sreset();
      for (int m = 1; m >= 0; m--) begin
         tick(1);
         I_SHIFT_MODE_SELECT = m[0];
         tick(4);
         xmit(80'h1b, 8, 1'b0);
         xmit(80'h16, 5, 1'b0);
         drain();
         chk("pending", 16'(expq.size()), 16'h0000);
         chk("fast spacing", 16'(gap), 16'(SYM_CYC_HS));
      end
      $display("test modes done");
      I_RATE_SELECT = 1'b1;
      tick(4);
      xmit(80'h2d, 6, 1'b0);
      drain();
      chk("slow spacing", 16'(gap), 16'(SYM_CYC_LS));
      I_RATE_SELECT = 1'b0;
      $display("test rate done");
      I_RESET_POWERDOWN_N = 1'b0;
      // Bit clocks after the core stops, else the buffer keeps stale write pointers
      tick(4);
      i_bit_source.idle(4);
      tick(1);
      chk("core held", O_CORE_RUN, 1'b0);
      chk("i held", O_I_LEVEL, LEVEL_FULL);
      I_RESET_POWERDOWN_N = 1'b1;
      w = 0;
      while (O_CORE_RUN !== 1'b1 && w < 20) begin
         tick(1);
         w++;
      end
      chk("release edges", 16'(w), 16'h0003);
      i_bit_source.idle(4);
      eph = PHASE_RESET;
      eiq = 2'h0;
      prbs = PRBS_SEED;
      mon_seen = 1'b0;
      I_TEST_PATTERN_SELECT = 1'b1;
      i_bit_source.idle(4);
      // Idle clocks between slots must not restart the sequence
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 8; k++) begin
            pb = {pb[78:0], prbs[8]};
            prbs = {prbs[7:0], prbs[8] ^ prbs[4]};
         end
         xmit(pb, 8, 1'b1);
         i_bit_source.idle(3);
      end
      drain();
      chk("pending", 16'(expq.size()), 16'h0000);
      chk("monitor", mon_seen, 1'b1);
      I_TEST_PATTERN_SELECT = 1'b0;
      i_bit_source.idle(4);
      $display("test pattern done");
      nsym = 0;
      xmit(80'h0, 80, 1'b0);
      drain();
      expq.delete();
      chk("overrun", O_FIFO_OVERRUN, 1'b1);
      chk("buffered", 16'(nsym >= FIFO_DEPTH), 16'h0001);
      sreset();
      chk("overrun cleared", O_FIFO_OVERRUN, 1'b0);
      $display("test buffer done");
      conclude();
   end
endmodule
